// file: mixer_ctrl_dev.sv
// mixer device end: serial shift path, byte decode, staged and active settings
`timescale 1ns/10ps
module mixer_ctrl_dev
	import mixer_pkg::*;
(
	// core clock and reset
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_n_i,
	// serial link, clocked by the link clock
	mixer_link_if.dev_mp                       link,
	// attenuator_cell settings
	output logic [N_CH-1:0][GAIN_W-1:0]        gain_o,
	output logic [N_CH-1:0]                    mute_o,
	output logic [N_CH-1:0]                    route_left_o,
	output logic [N_CH-1:0]                    route_right_o
);

	// ---- link clock domain ----
	logic                  frame_clr;
	logic [BIT_CNT_W-1:0]  bit_cnt_r;
	logic [BYTE_W-1:0]     shift_r;
	logic [BYTE_W-1:0]     byte_r;
	logic                  byte_tgl_r;
	logic [BYTE_W-1:0]     byte_in;

	// bit count only runs while write is low; ended by the frame itself
	assign frame_clr = link.write_n | ~rst_n_i;
	assign byte_in   = {shift_r[BYTE_W-2:0], link.sdi};

	always_ff @(posedge link.sclk or posedge frame_clr) begin
		if (frame_clr) begin
			bit_cnt_r <= '0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 1'b1;
		end
	end

	// shift path: msb arrives first and walks to the top bit
	always_ff @(posedge link.sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_r <= BYTE_RST;
		end else begin
			shift_r <= byte_in;
		end
	end

	// chain output is the bit leaving the top of the shift path
	assign link.sdo = shift_r[BYTE_W-1];

	// whole byte captured and announced by a toggle
	always_ff @(posedge link.sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			byte_r     <= BYTE_RST;
			byte_tgl_r <= 1'b0;
		end else if (bit_cnt_r == BIT_CNT_W'(BYTE_W - 1)) begin
			byte_r     <= byte_in;
			byte_tgl_r <= ~byte_tgl_r;
		end
	end

	// ---- core clock domain ----
	logic                  tgl_s1_r;
	logic                  tgl_s2_r;
	logic                  tgl_s3_r;
	logic                  load_s1_r;
	logic                  load_s2_r;
	logic                  load_s3_r;
	logic                  byte_evt;
	logic                  load_evt;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
		end else begin
			tgl_s1_r <= byte_tgl_r;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			load_s1_r <= 1'b1;
			load_s2_r <= 1'b1;
			load_s3_r <= 1'b1;
		end else begin
			load_s1_r <= link.load_strobe_n;
			load_s2_r <= load_s1_r;
			load_s3_r <= load_s2_r;
		end
	end

	assign byte_evt = tgl_s2_r ^ tgl_s3_r;
	// end of load strobe; with load tied to write this is end of write
	assign load_evt = load_s2_r & ~load_s3_r;

	function automatic logic is_addr_byte(input logic [BYTE_W-1:0] b);
		return b[SEL_BIT];
	endfunction

	// selected channel and whether one has been addressed
	logic [CH_W-1:0]       cur_ch_r;
	logic                  ch_valid_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cur_ch_r   <= CH_RST;
			ch_valid_r <= 1'b0;
		end else if (byte_evt && is_addr_byte(byte_r)) begin
			cur_ch_r   <= byte_r[ADDR_CH_LSB +: CH_W];
			ch_valid_r <= 1'b1;
		end else if (load_evt) begin
			ch_valid_r <= 1'b0;
		end
	end

	// per channel staged settings, applied together on load
	genvar ch;
	generate
		for (ch = 0; ch < N_CH; ch++) begin : g_ch
			logic              sel_addr;
			logic              sel_gain;
			logic [GAIN_W-1:0] pend_gain_r;
			logic              pend_mute_r;
			logic              pend_left_r;
			logic              pend_right_r;
			logic [GAIN_W-1:0] pend_gain_nxt;
			logic              pend_mute_nxt;
			logic              pend_left_nxt;
			logic              pend_right_nxt;

			assign sel_addr = byte_evt && is_addr_byte(byte_r)
				&& (byte_r[ADDR_CH_LSB +: CH_W] == CH_W'(ch));
			assign sel_gain = byte_evt && !is_addr_byte(byte_r)
				&& ch_valid_r && (cur_ch_r == CH_W'(ch));

			always_comb begin
				pend_gain_nxt  = pend_gain_r;
				pend_mute_nxt  = pend_mute_r;
				pend_left_nxt  = pend_left_r;
				pend_right_nxt = pend_right_r;
				if (sel_addr) begin
					pend_left_nxt  = byte_r[ADDR_LEFT_BIT];
					pend_right_nxt = byte_r[ADDR_RIGHT_BIT];
				end
				if (sel_gain) begin
					pend_gain_nxt = byte_r[GAIN_LSB +: GAIN_W];
					pend_mute_nxt = byte_r[GAIN_MUTE_BIT];
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					pend_gain_r  <= GAIN_RST;
					pend_mute_r  <= MUTE_RST;
					pend_left_r  <= ROUTE_RST;
					pend_right_r <= ROUTE_RST;
				end else begin
					pend_gain_r  <= pend_gain_nxt;
					pend_mute_r  <= pend_mute_nxt;
					pend_left_r  <= pend_left_nxt;
					pend_right_r <= pend_right_nxt;
				end
			end

			// a byte landing in the load cycle is still applied
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					gain_o[ch]        <= GAIN_RST;
					mute_o[ch]        <= MUTE_RST;
					route_left_o[ch]  <= ROUTE_RST;
					route_right_o[ch] <= ROUTE_RST;
				end else if (load_evt) begin
					gain_o[ch]        <= pend_gain_nxt;
					mute_o[ch]        <= pend_mute_nxt;
					route_left_o[ch]  <= pend_left_nxt;
					route_right_o[ch] <= pend_right_nxt;
				end
			end
		end
	endgenerate

endmodule

// file: mixer_ctrl_host.sv
// host end: sends address and gain bytes, then load, in three- or four-wire form
`timescale 1ns/10ps
module mixer_ctrl_host
	import mixer_pkg::*;
(
	// core clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_n_i,
	// user request
	input  wire logic              three_wire_i,
	input  wire logic              req_valid_i,
	output logic                   req_ready_o,
	input  wire logic [CH_W-1:0]   req_ch_i,
	input  wire logic              req_left_i,
	input  wire logic              req_right_i,
	input  wire logic              req_mute_i,
	input  wire logic [GAIN_W-1:0] req_gain_i,
	// chain return, synchronised
	output logic                   chain_sdo_o,
	// serial link
	mixer_link_if.host_mp          link
);

	host_state_t             state_r;
	logic [WAIT_W-1:0]       wait_r;
	logic [FRAME_BITS-1:0]   frame_r;
	logic [3:0]              bit_idx_r;
	logic                    three_r;
	logic                    sclk_r;
	logic                    sdi_r;
	logic                    write_n_r;
	logic                    load_n_r;
	logic                    sdo_s1_r;
	logic                    sdo_s2_r;
	logic                    wait_done;

	assign wait_done      = (wait_r == '0);
	assign req_ready_o    = (state_r == H_IDLE);
	assign link.sclk      = sclk_r;
	assign link.sdi       = sdi_r;
	assign link.write_n   = write_n_r;
	assign link.load_strobe_n = load_n_r;
	assign chain_sdo_o    = sdo_s2_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sdo_s1_r <= 1'b0;
			sdo_s2_r <= 1'b0;
		end else begin
			sdo_s1_r <= link.sdo;
			sdo_s2_r <= sdo_s1_r;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_r   <= H_IDLE;
			wait_r    <= '0;
			frame_r   <= '0;
			bit_idx_r <= '0;
			three_r   <= 1'b0;
			sclk_r    <= 1'b0;
			sdi_r     <= 1'b0;
			write_n_r <= 1'b1;
			load_n_r  <= 1'b1;
		end else begin
			unique case (state_r)
				H_IDLE: begin
					if (req_valid_i) begin
						frame_r   <= {1'b1, 2'h0, req_right_i, req_left_i, req_ch_i,
							1'b0, req_mute_i, req_gain_i};
						three_r   <= three_wire_i;
						write_n_r <= 1'b0;
						load_n_r  <= three_wire_i ? 1'b0 : 1'b1;
						wait_r    <= WC_CYC - 1'b1;
						state_r   <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (wait_done) begin
						sdi_r     <= frame_r[FRAME_BITS-1];
						bit_idx_r <= 4'(FRAME_BITS - 1);
						wait_r    <= HALF_CYC - 1'b1;
						state_r   <= H_SHIFT;
					end else begin
						wait_r <= wait_r - 1'b1;
					end
				end
				H_SHIFT: begin
					if (!wait_done) begin
						wait_r <= wait_r - 1'b1;
					end else if (!sclk_r) begin
						sclk_r <= 1'b1;
						wait_r <= HALF_CYC - 1'b1;
					end else begin
						sclk_r <= 1'b0;
						if (bit_idx_r == 4'h0) begin
							state_r <= H_WEND;
							wait_r  <= WL_CYC - 1'b1;
						end else begin
							bit_idx_r <= bit_idx_r - 1'b1;
							sdi_r     <= frame_r[bit_idx_r - 1'b1];
							wait_r    <= HALF_CYC - 1'b1;
						end
					end
				end
				H_WEND: begin
					if (write_n_r == 1'b0) begin
						write_n_r <= 1'b1;
						load_n_r  <= 1'b1;
						wait_r    <= WL_CYC - 1'b1;
					end else if (!wait_done) begin
						wait_r <= wait_r - 1'b1;
					end else if (three_r) begin
						wait_r  <= LW_CYC - 1'b1;
						state_r <= H_GAP;
					end else begin
						load_n_r <= 1'b0;
						wait_r   <= LOAD_CYC - 1'b1;
						state_r  <= H_LOAD;
					end
				end
				H_LOAD: begin
					if (wait_done) begin
						load_n_r <= 1'b1;
						wait_r   <= LW_CYC - 1'b1;
						state_r  <= H_GAP;
					end else begin
						wait_r <= wait_r - 1'b1;
					end
				end
				H_GAP: begin
					if (wait_done) begin
						state_r <= H_IDLE;
					end else begin
						wait_r <= wait_r - 1'b1;
					end
				end
			endcase
		end
	end

endmodule

// file: mixer_link_if.sv
// serial link between host controller and mixer control logic
`timescale 1ns/10ps
interface mixer_link_if;
	logic sclk;
	logic sdi;
	logic write_n;
	logic load_strobe_n;
	logic sdo;

	modport host_mp (
		output sclk,
		output sdi,
		output write_n,
		output load_strobe_n,
		input  sdo
	);

	modport dev_mp (
		input  sclk,
		input  sdi,
		input  write_n,
		input  load_strobe_n,
		output sdo
	);
endinterface

// file: mixer_pkg.sv
// shared constants and types for the mixer serial gain control link
package mixer_pkg;

	// channel and field geometry
	localparam int N_CH          = 8;
	localparam int CH_W          = 3;
	localparam int GAIN_W        = 6;
	localparam int BYTE_W        = 8;
	localparam int FRAME_BITS    = 16;
	localparam int BIT_CNT_W     = 3;

	// byte layout: bit 7 high = address byte, low = gain byte
	localparam int SEL_BIT       = 7;
	localparam int ADDR_CH_LSB   = 0;
	localparam int ADDR_LEFT_BIT = 3;
	localparam int ADDR_RIGHT_BIT = 4;
	localparam int GAIN_MUTE_BIT = 6;
	localparam int GAIN_LSB      = 0;

	// values after reset
	localparam logic [GAIN_W-1:0] GAIN_RST  = 6'h00;
	localparam logic              MUTE_RST  = 1'b1;
	localparam logic              ROUTE_RST = 1'b0;
	localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
	localparam logic [CH_W-1:0]   CH_RST    = 3'h0;

	// link timing, ns, and derived core clock counts (least times round up)
	localparam int CORE_CLK_NS   = 50;
	localparam int T_CLK_HALF_NS = 50;
	localparam int T_WC_NS       = 35;
	localparam int T_WL_NS       = 20;
	localparam int T_LW_NS       = 20;
	localparam int T_LOAD_NS     = 250;
	localparam int WAIT_W        = 4;
	localparam logic [WAIT_W-1:0] HALF_CYC =
		WAIT_W'((T_CLK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
	localparam logic [WAIT_W-1:0] WC_CYC   = WAIT_W'((T_WC_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
	localparam logic [WAIT_W-1:0] WL_CYC   = WAIT_W'((T_WL_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
	localparam logic [WAIT_W-1:0] LW_CYC   = WAIT_W'((T_LW_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
	localparam logic [WAIT_W-1:0] LOAD_CYC = WAIT_W'((T_LOAD_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);

	// host sequencer states
	typedef enum logic [5:0] {
		H_IDLE  = 6'h01,
		H_SETUP = 6'h02,
		H_SHIFT = 6'h04,
		H_WEND  = 6'h08,
		H_LOAD  = 6'h10,
		H_GAP   = 6'h20
	} host_state_t;

endpackage

// file: mixer_serial_gain_control_chk.sv
// wire-level checks of the mixer serial link
`timescale 1ns/10ps
module mixer_serial_gain_control_chk (
	// core clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	// link
	input  wire logic sclk,
	input  wire logic sdi,
	input  wire logic write_n,
	input  wire logic load_strobe_n,
	input  wire logic sdo
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_load_pulse;
		!load_strobe_n [*5] ##1 load_strobe_n;
	endsequence
	sequence s_frame_end;
		##[32:36] $rose(write_n);
	endsequence

	property p_sclk_idle;  write_n |-> !sclk; endproperty
	property p_sdi_hold;   sclk |-> $stable(sdi); endproperty
	property p_sclk_high;  $rose(sclk) |=> $fell(sclk); endproperty
	property p_sdo_edge;   $changed(sdo) |-> $rose(sclk); endproperty
	property p_load_order; $fell(load_strobe_n) |-> $fell(write_n) || $past(write_n); endproperty
	property p_load_width; $fell(load_strobe_n) && write_n |-> s_load_pulse; endproperty
	property p_load_end;   $rose(load_strobe_n) |-> write_n; endproperty
	property p_frame;      $fell(write_n) |-> s_frame_end; endproperty

	a_sclk_idle:  assert property (p_sclk_idle)  else $error("sclk not idle low");
	a_sdi_hold:   assert property (p_sdi_hold)   else $error("sdi moved while sclk high");
	a_sclk_high:  assert property (p_sclk_high)  else $error("sclk high too long");
	a_sdo_edge:   assert property (p_sdo_edge)   else $error("sdo moved off rising sclk");
	a_load_order: assert property (p_load_order) else $error("load began during write");
	a_load_width: assert property (p_load_width) else $error("load pulse width wrong");
	a_load_end:   assert property (p_load_end)   else $error("load ended with write low");
	a_frame:      assert property (p_frame)      else $error("frame length wrong");
endmodule

// file: mixer_serial_gain_control_tb.sv
// self-checking bench: host and device ends joined by the link
`timescale 1ns/10ps
module mixer_serial_gain_control_tb;
	import mixer_pkg::*;
	logic                       core_clk_i = 1'b0;
	logic                       rst_n_i    = 1'b0;
	logic                       three_wire = 1'b0;
	logic                       req_valid  = 1'b0;
	logic                       req_ready;
	logic [CH_W-1:0]            req_ch     = 3'h0;
	logic                       req_left   = 1'b0;
	logic                       req_right  = 1'b0;
	logic                       req_mute   = 1'b0;
	logic [GAIN_W-1:0]          req_gain   = 6'h00;
	logic                       chain_sdo;
	logic [N_CH-1:0][GAIN_W-1:0] gain, exp_gain;
	logic [N_CH-1:0]            mute, route_l, route_r, exp_mute, exp_l, exp_r;
	logic [7:0]                 hist;
	logic                       prev_top;
	int                         n_rise;
	int                         n_mismatch = 0;
	int                         samples_checked = 0;

	always #25 core_clk_i = ~core_clk_i;

	mixer_link_if link ();
	mixer_ctrl_host i_mixer_ctrl_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .three_wire_i(three_wire),
		.req_valid_i(req_valid), .req_ready_o(req_ready), .req_ch_i(req_ch), .req_left_i(req_left),
		.req_right_i(req_right), .req_mute_i(req_mute), .req_gain_i(req_gain), .chain_sdo_o(chain_sdo),
		.link(link));
	mixer_ctrl_dev i_mixer_ctrl_dev (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link), .gain_o(gain),
		.mute_o(mute), .route_left_o(route_l), .route_right_o(route_r));
	mixer_serial_gain_control_chk i_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk(link.sclk),
		.sdi(link.sdi), .write_n(link.write_n), .load_strobe_n(link.load_strobe_n), .sdo(link.sdo));

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chk_all();
		chk(gain, exp_gain);
		chk({40'h0, mute}, {40'h0, exp_mute});
		chk({40'h0, route_l}, {40'h0, exp_l});
		chk({40'h0, route_r}, {40'h0, exp_r});
	endtask

	// device shift path model: sdo shows the bit taken seven rises back
	always @(posedge link.sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hist <= 8'h00;
			prev_top <= 1'b0;
			n_rise <= 0;
		end else begin
			hist <= {hist[6:0], link.sdi};
			prev_top <= hist[7];
			n_rise <= n_rise + 1;
		end
	end
	// chain return lags sdo by two core flops: shows sdo from before the last rise
	always @(negedge link.sclk) begin
		if (n_rise >= 8) chk({47'h0, link.sdo}, {47'h0, hist[7]});
		#2;
		if (n_rise >= 8) chk({47'h0, chain_sdo}, {47'h0, prev_top});
	end

	task automatic do_reset();
		rst_n_i = 1'b0;
		repeat (2) @(posedge core_clk_i);
		#2 rst_n_i = 1'b1;
		exp_gain = '0;
		exp_mute = '1;
		exp_l = '0;
		exp_r = '0;
		repeat (2) @(posedge core_clk_i);
		#2 chk_all();
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic send(input logic [2:0] ch, input logic l, input logic r, input logic m,
		input logic [5:0] g, input logic tw);
		int k;
		three_wire = tw;
		req_ch = ch;
		req_left = l;
		req_right = r;
		req_mute = m;
		req_gain = g;
		req_valid = 1'b1;
		@(posedge core_clk_i);
		#2 req_valid = 1'b0;
		repeat (20) @(posedge core_clk_i);
		#2 chk_all();
		k = 0;
		while (req_ready !== 1'b1 && k < 100) begin
			@(posedge core_clk_i);
			#2 k++;
		end
		if (k >= 100) begin
			n_mismatch++;
			$display("FAIL %0t host never idle", $time);
		end else begin
			exp_gain[ch] = g;
			exp_mute[ch] = m;
			exp_l[ch] = l;
			exp_r[ch] = r;
			repeat (2) @(posedge core_clk_i);
			#2 chk_all();
		end
	endtask

	initial begin
		int i;
		void'($urandom(60));
		do_reset();
		$display("test reset done");
		for (i = 0; i < 8; i++) send(3'(i), i[0], i[1], 1'b0, i[2] ? 6'h3f : 6'h00, i[0]);
		$display("test corners done");
		for (i = 0; i < 24; i++) send(3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 6'($urandom),
			1'($urandom));
		$display("test random done");
		do_reset();
		send(3'h7, 1'b1, 1'b1, 1'b0, 6'h21, 1'b0);
		$display("test second reset done");
		wrap_up();
	end
endmodule
